// >>> rtl/rtc_pkg.sv
/*
 * Constants and types for the indexed clock/calendar with alarm and storage bytes.
 * Assumes a single clock domain and a host that drives byte-wide port strobes.
 */
package rtc_pkg;

	// ------------------------------------------------------------------
	// Host ports and location indexes
	// ------------------------------------------------------------------
	localparam logic [7:0] PORT_INDEX = 8'h70;
	localparam logic [7:0] PORT_DATA = 8'h71;
	localparam logic [7:0] PORT_IDLE_READ = 8'h00;

	localparam logic [6:0] LOC_SEC = 7'h00;
	localparam logic [6:0] LOC_ALM_SEC = 7'h01;
	localparam logic [6:0] LOC_MIN = 7'h02;
	localparam logic [6:0] LOC_ALM_MIN = 7'h03;
	localparam logic [6:0] LOC_HR = 7'h04;
	localparam logic [6:0] LOC_ALM_HR = 7'h05;
	localparam logic [6:0] LOC_DOW = 7'h06;
	localparam logic [6:0] LOC_DOM = 7'h07;
	localparam logic [6:0] LOC_MON = 7'h08;
	localparam logic [6:0] LOC_YR = 7'h09;
	localparam logic [6:0] LOC_CTRL_A = 7'h0a;
	localparam logic [6:0] LOC_CTRL_B = 7'h0b;
	localparam logic [6:0] LOC_FLAGS = 7'h0c;
	localparam logic [6:0] LOC_VALID = 7'h0d;
	localparam int RAM_FIRST = 14;
	localparam int RAM_LAST = 127;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int A_UIP = 7;
	localparam int A_DIV_HI = 6;
	localparam int A_DIV_LO = 4;
	localparam logic [2:0] DIV_RUN = 3'h2;
	localparam int B_SET = 7;
	localparam int B_PIE = 6;
	localparam int B_AIE = 5;
	localparam int B_UIE = 4;
	localparam int B_BIN = 2;
	localparam int B_24H = 1;
	localparam int B_DSE = 0;
	localparam int C_IRQF = 7;
	localparam int C_PF = 6;
	localparam int C_AF = 5;
	localparam int C_UF = 4;
	localparam logic [1:0] ALARM_ANY = 2'h3;

	// ------------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_A_RST = 8'h20;
	localparam logic [7:0] CTRL_B_RST = 8'h02;
	localparam logic [7:0] DAY_ONE = 8'h01;
	localparam logic [31:0] TB_HZ = 32'h0000_8000;
	localparam logic [31:0] CLK_HZ = 32'h017D_7840;
	localparam int UIP_TICKS = 8;

	// ------------------------------------------------------------------
	// Calendar limits, binary
	// ------------------------------------------------------------------
	localparam logic [6:0] LIM_MIN_SEC = 7'h3c;
	localparam logic [6:0] LIM_HOUR = 7'h18;
	localparam logic [6:0] HALF_DAY = 7'h0c;
	localparam logic [6:0] DOW_LAST = 7'h07;
	localparam logic [6:0] MON_LAST = 7'h0c;
	localparam logic [6:0] YR_LAST = 7'h63;
	localparam logic [6:0] SUNDAY = 7'h01;
	localparam logic [6:0] DST_HOUR = 7'h01;
	localparam logic [6:0] DST_SKIP_TO = 7'h03;
	localparam logic [6:0] DST_FALL_END = 7'h02;
	localparam logic [6:0] DST_SPRING_MON = 7'h04;
	localparam logic [6:0] DST_SPRING_DAY = 7'h18;
	localparam logic [6:0] DST_FALL_MON = 7'h0a;
	localparam logic [6:0] DST_FALL_DAY = 7'h19;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hr;
		logic [7:0] dow;
		logic [7:0] dom;
		logic [7:0] mon;
		logic [7:0] yr;
	} rtc_time_s;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hr;
	} rtc_alarm_s;

endpackage

// >>> rtl/rtc_calendar.sv
/*
 * Clock/calendar with alarm, periodic and update-ended events and storage bytes,
 * reached through an index port and a data port.
 * Assumes host strobes are synchronous to ref_clk_i and last one cycle per access.
 */

// Function
// R1: Host writes the index port with a location number 00h to 7Fh.
// R2: Data port reads or writes the location chosen by the index.
// R3: Host always writes index first, then accesses the data port.
// R4: Time and date bytes sit at 00h, 02h, 04h, 06h, 07h, 08h, 09h.
// R5: Update-in-progress bit 7 of control A is read-only and high near updates.
// R6: Bits 6-4 of control A choose the divider; 010 runs the clock.
// R7: Low four bits of control A choose the periodic event rate.
// R8: Control B bit 7 set stops clock and calendar updates.
// R9: Control B bit 6 lets periodic events raise the interrupt.
// R10: Control B bit 5 lets an alarm match raise the interrupt.
// R11: Control B bit 4 lets each once-a-second update raise the interrupt.
// R12: Control B bit 2 picks BCD (0) or binary (1) for time bytes.
// R13: Control B bit 1 picks 12-hour (0) or 24-hour (1) hours.
// R14: Control B bit 0 turns on automatic daylight saving adjustment.
// R15: Flag bit 7 and the interrupt rise on any enabled event.
// R16: Periodic, alarm and update flags set even when not enabled.
// R17: Reading the flag location returns then clears all flags.
// R18: Location D bit 7 always reads 1, marking time valid.
// R19: Location D bits 5-0 hold the alarm day, used in matching.
// R20: Spare locations give general storage bytes through the same ports.
// R21: Host leaves undescribed locations alone for firmware use.
// R22: Alarm seconds, minutes, hours sit at 01h, 03h, 05h and are compared.
// R23: Control B bit 3 is stored and otherwise ignored.
module rtc_calendar #(
	parameter logic [31:0] CLK_HZ = rtc_pkg::CLK_HZ,
	parameter logic [31:0] TB_HZ = rtc_pkg::TB_HZ,
	parameter int PRESC_W = 15
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	output logic irq_o
);
	// ------------------------------------------------------------------
	// Number helpers
	// ------------------------------------------------------------------
	function automatic logic [6:0] to_bin(input logic [7:0] v, input logic bin);
		if (bin)
			return v[6:0];
		return 7'({3'h0, v[7:4]} * 7'd10 + {3'h0, v[3:0]});
	endfunction
	function automatic logic [7:0] from_bin(input logic [6:0] b, input logic bin);
		logic [6:0] t;
		logic [6:0] u;
		t = b / 7'd10;
		u = 7'(b - 7'(t * 7'd10));
		if (bin)
			return {1'b0, b};
		return {t[3:0], u[3:0]};
	endfunction
	function automatic logic [6:0] hr_to24(input logic [7:0] hr, input logic bin,
		input logic m24);
		logic [6:0] v;
		v = to_bin({1'b0, hr[6:0]}, bin);
		if (m24)
			return to_bin(hr, bin);
		if (v == rtc_pkg::HALF_DAY)
			v = 7'h00;
		return hr[7] ? 7'(v + rtc_pkg::HALF_DAY) : v;
	endfunction
	function automatic logic [7:0] hr_from24(input logic [6:0] h, input logic bin,
		input logic m24);
		logic pm;
		logic [6:0] v;
		logic [7:0] e;
		pm = h >= rtc_pkg::HALF_DAY;
		v = pm ? 7'(h - rtc_pkg::HALF_DAY) : h;
		if (v == 7'h00)
			v = rtc_pkg::HALF_DAY;
		e = from_bin(v, bin);
		if (m24)
			return from_bin(h, bin);
		return {pm, e[6:0]};
	endfunction
	function automatic logic [6:0] month_days(input logic [6:0] mo, input logic [6:0] yr);
		case (mo)
			7'd2: return (yr[1:0] == 2'b00) ? 7'd29 : 7'd28;
			7'd4, 7'd6, 7'd9, 7'd11: return 7'd30;
			default: return 7'd31;
		endcase
	endfunction
	// Rates 1 and 2 fall back to slower periods, as continuing the pattern of rates 3 and up would make them too fast.
	function automatic logic periodic_hit(input logic [3:0] rate, input logic [PRESC_W-1:0] cnt);
		int sh;
		logic [PRESC_W-1:0] m;
		sh = (rate < 4'd3) ? int'(rate) + 7 : int'(rate) - 1;
		m = PRESC_W'((64'h1 << sh) - 64'h1);
		return (rate != 4'h0) && ((cnt & m) == '0);
	endfunction
	function automatic logic alarm_eq(input logic [7:0] a, input logic [7:0] t);
		return (a[7:6] == rtc_pkg::ALARM_ANY) || (a == t);
	endfunction
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [6:0] index_q, index_d;
	rtc_pkg::rtc_time_s time_q, time_d;
	rtc_pkg::rtc_alarm_s alarm_q, alarm_d;
	logic [6:0] ctrl_a_q, ctrl_a_d;
	logic [7:0] ctrl_b_q, ctrl_b_d;
	logic [7:0] flags_q, flags_d;
	logic [5:0] alarm_day_q, alarm_day_d;
	logic fall_q, fall_d;
	logic [31:0] acc_q, acc_d;
	logic [PRESC_W-1:0] presc_q, presc_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] ram_q [rtc_pkg::RAM_FIRST:rtc_pkg::RAM_LAST];
	logic wr_data, rd_data, tick, running, upd, per_ev, alarm_ev, uip;
	logic bin, m24, flag_clr;
	logic [31:0] acc_sum;
	logic [6:0] s, m, hh, oh, dw, dm, mo, y;
	logic [7:0] loc_rd;
	assign wr_data = io_wr_i && (io_addr_i == rtc_pkg::PORT_DATA);
	assign rd_data = io_rd_i && (io_addr_i == rtc_pkg::PORT_DATA);
	assign bin = ctrl_b_q[rtc_pkg::B_BIN];
	assign m24 = ctrl_b_q[rtc_pkg::B_24H];
	// R6: divider field gates the timebase
	assign running = ctrl_a_q[rtc_pkg::A_DIV_HI:rtc_pkg::A_DIV_LO] == rtc_pkg::DIV_RUN;
	// R5: busy window just before the update
	assign uip = running && !ctrl_b_q[rtc_pkg::B_SET] &&
		(presc_q >= PRESC_W'((64'h1 << PRESC_W) - 64'(rtc_pkg::UIP_TICKS)));

	// ------------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------------
	always_comb
	begin
		loc_rd = 8'h00;
		case (index_q)
			rtc_pkg::LOC_SEC: loc_rd = time_q.sec;
			rtc_pkg::LOC_ALM_SEC: loc_rd = alarm_q.sec;
			rtc_pkg::LOC_MIN: loc_rd = time_q.min;
			rtc_pkg::LOC_ALM_MIN: loc_rd = alarm_q.min;
			rtc_pkg::LOC_HR: loc_rd = time_q.hr;
			rtc_pkg::LOC_ALM_HR: loc_rd = alarm_q.hr;
			rtc_pkg::LOC_DOW: loc_rd = time_q.dow;
			rtc_pkg::LOC_DOM: loc_rd = time_q.dom;
			rtc_pkg::LOC_MON: loc_rd = time_q.mon;
			rtc_pkg::LOC_YR: loc_rd = time_q.yr;
			rtc_pkg::LOC_CTRL_A: loc_rd = {uip, ctrl_a_q};
			rtc_pkg::LOC_CTRL_B: loc_rd = ctrl_b_q;
			rtc_pkg::LOC_FLAGS: loc_rd = flags_q;
			// R18: valid bit fixed high
			rtc_pkg::LOC_VALID: loc_rd = {1'b1, 1'b0, alarm_day_q};
			// R20: storage bytes
			default: loc_rd = ram_q[index_q];
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		index_d = index_q;
		time_d = time_q;
		alarm_d = alarm_q;
		ctrl_a_d = ctrl_a_q;
		ctrl_b_d = ctrl_b_q;
		alarm_day_d = alarm_day_q;
		fall_d = fall_q;
		rdata_d = rdata_q;
		alarm_ev = 1'b0;
		acc_sum = acc_q + TB_HZ;
		tick = acc_sum >= CLK_HZ;
		acc_d = tick ? acc_sum - CLK_HZ : acc_sum;
		presc_d = !running ? '0 : (tick ? presc_q + 1'b1 : presc_q);
		// R8: updates held off while set
		upd = running && tick && (presc_q == '1) && !ctrl_b_q[rtc_pkg::B_SET];
		// R7: rate field picks the periodic period
		per_ev = running && tick && periodic_hit(ctrl_a_q[3:0], presc_d);
		// R12: all arithmetic in binary, bytes in chosen format
		s = to_bin(time_q.sec, bin);
		m = to_bin(time_q.min, bin);
		// R13: hours held internally as 0..23
		hh = hr_to24(time_q.hr, bin, m24);
		oh = hh;
		dw = to_bin(time_q.dow, bin);
		dm = to_bin(time_q.dom, bin);
		mo = to_bin(time_q.mon, bin);
		y = to_bin(time_q.yr, bin);
		if (upd)
		begin
			s = s + 7'd1;
			if (s >= rtc_pkg::LIM_MIN_SEC)
			begin
				s = 7'h00;
				m = m + 7'd1;
				if (m >= rtc_pkg::LIM_MIN_SEC)
				begin
					m = 7'h00;
					hh = hh + 7'd1;
					// R14: spring skip and single fall repeat
					if (ctrl_b_q[rtc_pkg::B_DSE] && dw == rtc_pkg::SUNDAY && oh == rtc_pkg::DST_HOUR)
					begin
						if (mo == rtc_pkg::DST_SPRING_MON && dm >= rtc_pkg::DST_SPRING_DAY)
							hh = rtc_pkg::DST_SKIP_TO;
						else if (mo == rtc_pkg::DST_FALL_MON && dm >= rtc_pkg::DST_FALL_DAY && !fall_q)
						begin
							hh = rtc_pkg::DST_HOUR;
							fall_d = 1'b1;
						end
					end
					if (hh == rtc_pkg::DST_FALL_END)
						fall_d = 1'b0;
					if (hh >= rtc_pkg::LIM_HOUR)
					begin
						hh = 7'h00;
						dw = (dw >= rtc_pkg::DOW_LAST) ? 7'd1 : dw + 7'd1;
						dm = dm + 7'd1;
						if (dm > month_days(mo, y))
						begin
							dm = 7'd1;
							mo = mo + 7'd1;
							if (mo > rtc_pkg::MON_LAST)
							begin
								mo = 7'd1;
								y = (y >= rtc_pkg::YR_LAST) ? 7'h00 : y + 7'd1;
							end
						end
					end
				end
			end
			// R4: fields written back at their own locations
			time_d.sec = from_bin(s, bin);
			time_d.min = from_bin(m, bin);
			time_d.hr = hr_from24(hh, bin, m24);
			time_d.dow = from_bin(dw, bin);
			time_d.dom = from_bin(dm, bin);
			time_d.mon = from_bin(mo, bin);
			time_d.yr = from_bin(y, bin);
			// R22: alarm compared with the new time
			// R19: alarm day zero matches any day
			alarm_ev = alarm_eq(alarm_q.sec, time_d.sec) && alarm_eq(alarm_q.min, time_d.min) &&
				alarm_eq(alarm_q.hr, time_d.hr) &&
				(alarm_day_q == 6'h00 || alarm_day_q == time_d.dom[5:0]);
		end
		// R1: index port takes the low seven bits
		if (io_wr_i && io_addr_i == rtc_pkg::PORT_INDEX)
			index_d = io_wdata_i[6:0];
		// R2: host write to the selected location wins over the update
		if (wr_data)
		begin
			case (index_q)
				rtc_pkg::LOC_SEC: time_d.sec = io_wdata_i;
				rtc_pkg::LOC_ALM_SEC: alarm_d.sec = io_wdata_i;
				rtc_pkg::LOC_MIN: time_d.min = io_wdata_i;
				rtc_pkg::LOC_ALM_MIN: alarm_d.min = io_wdata_i;
				rtc_pkg::LOC_HR: time_d.hr = io_wdata_i;
				rtc_pkg::LOC_ALM_HR: alarm_d.hr = io_wdata_i;
				rtc_pkg::LOC_DOW: time_d.dow = io_wdata_i;
				rtc_pkg::LOC_DOM: time_d.dom = io_wdata_i;
				rtc_pkg::LOC_MON: time_d.mon = io_wdata_i;
				rtc_pkg::LOC_YR: time_d.yr = io_wdata_i;
				rtc_pkg::LOC_CTRL_A: ctrl_a_d = io_wdata_i[6:0];
				// R23: square-wave bit only stored
				rtc_pkg::LOC_CTRL_B: ctrl_b_d = io_wdata_i;
				rtc_pkg::LOC_VALID: alarm_day_d = io_wdata_i[5:0];
				default: ;
			endcase
		end
		// R16: event flags set regardless of enables
		// R17: read clears, a same-cycle event still lands
		flag_clr = rd_data && index_q == rtc_pkg::LOC_FLAGS;
		flags_d = 8'h00;
		flags_d[rtc_pkg::C_PF] = per_ev || (flags_q[rtc_pkg::C_PF] && !flag_clr);
		flags_d[rtc_pkg::C_AF] = alarm_ev || (flags_q[rtc_pkg::C_AF] && !flag_clr);
		flags_d[rtc_pkg::C_UF] = upd || (flags_q[rtc_pkg::C_UF] && !flag_clr);
		// R9: periodic enable
		// R10: alarm enable
		// R11: update-ended enable
		// R15: summary flag drives the interrupt
		flags_d[rtc_pkg::C_IRQF] =
			(flags_d[rtc_pkg::C_PF] && ctrl_b_q[rtc_pkg::B_PIE]) ||
			(flags_d[rtc_pkg::C_AF] && ctrl_b_q[rtc_pkg::B_AIE]) ||
			(flags_d[rtc_pkg::C_UF] && ctrl_b_q[rtc_pkg::B_UIE]);
		if (rd_data)
			rdata_d = loc_rd;
		else if (io_rd_i)
			rdata_d = rtc_pkg::PORT_IDLE_READ;
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			index_q <= 7'h00;
			time_q <= '{8'h00, 8'h00, 8'h00, rtc_pkg::DAY_ONE, rtc_pkg::DAY_ONE,
				rtc_pkg::DAY_ONE, 8'h00};
			alarm_q <= '0;
			ctrl_a_q <= rtc_pkg::CTRL_A_RST[6:0];
			ctrl_b_q <= rtc_pkg::CTRL_B_RST;
			flags_q <= 8'h00;
			alarm_day_q <= 6'h00;
			fall_q <= 1'b0;
			acc_q <= 32'h0000_0000;
			presc_q <= '0;
			rdata_q <= 8'h00;
		end
		else
		begin
			index_q <= index_d;
			time_q <= time_d;
			alarm_q <= alarm_d;
			ctrl_a_q <= ctrl_a_d;
			ctrl_b_q <= ctrl_b_d;
			flags_q <= flags_d;
			alarm_day_q <= alarm_day_d;
			fall_q <= fall_d;
			acc_q <= acc_d;
			presc_q <= presc_d;
			rdata_q <= rdata_d;
		end
	end
	// Storage bytes keep their content over reset, as battery-backed memory would.
	always_ff @(posedge ref_clk_i)
	begin
		if (wr_data && int'(index_q) >= rtc_pkg::RAM_FIRST)
			ram_q[index_q] <= io_wdata_i;
	end
	assign io_rdata_o = rdata_q;
	assign irq_o = flags_q[rtc_pkg::C_IRQF];

endmodule

// >>> testbench/rtc_calendar_asserts.sv
/*
 * Port-level checker for the indexed clock/calendar.
 * Assumes it is bound to the design top and sees only its ports.
 */
module rtc_calendar_asserts (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Shadow of index and control bytes
	// ----------------------------------------
	logic [6:0] idx_q, idx_d;
	logic [7:0] a_q, a_d, b_q, b_d;
	logic dw, dr;
	assign dw = io_wr_i && io_addr_i == rtc_pkg::PORT_DATA;
	assign dr = io_rd_i && io_addr_i == rtc_pkg::PORT_DATA;
	always_comb
	begin
		idx_d = (io_wr_i && io_addr_i == rtc_pkg::PORT_INDEX) ? io_wdata_i[6:0] : idx_q;
		a_d = (dw && idx_q == rtc_pkg::LOC_CTRL_A) ? io_wdata_i : a_q;
		b_d = (dw && idx_q == rtc_pkg::LOC_CTRL_B) ? io_wdata_i : b_q;
	end
	always_ff @(posedge ref_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			idx_q <= 7'h00;
			a_q <= rtc_pkg::CTRL_A_RST;
			b_q <= rtc_pkg::CTRL_B_RST;
		end
		else
		begin
			idx_q <= idx_d;
			a_q <= a_d;
			b_q <= b_d;
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	rdata_hold_a: assert property (!io_rd_i |=> $stable(io_rdata_o))
		else $error("read data changed without a read");
	other_port_a: assert property (io_rd_i && io_addr_i != rtc_pkg::PORT_DATA
		|=> io_rdata_o == 8'h00) else $error("non-data port read not zero");
	valid_bit_a: assert property (dr && idx_q == rtc_pkg::LOC_VALID
		|=> io_rdata_o[7:6] == 2'b10) else $error("valid bit wrong");
	flags_low_a: assert property (dr && idx_q == rtc_pkg::LOC_FLAGS
		|=> io_rdata_o[3:0] == 4'h0) else $error("reserved flag bits set");
	uip_set_a: assert property (dr && idx_q == rtc_pkg::LOC_CTRL_A && b_q[7]
		|=> !io_rdata_o[7]) else $error("update flag high while stopped");
	ctrl_a_rd_a: assert property (dr && idx_q == rtc_pkg::LOC_CTRL_A
		|=> io_rdata_o[6:0] == a_q[6:0]) else $error("control A readback wrong");
	ctrl_b_rd_a: assert property (dr && idx_q == rtc_pkg::LOC_CTRL_B
		|=> io_rdata_o == b_q) else $error("control B readback wrong");
	irq_enable_a: assert property (b_q[6:4] == 3'b000 |=> !irq_o)
		else $error("interrupt with no source enabled");
	irq_cause_a: assert property ($rose(irq_o) |-> $past(b_q[6:4]) != 3'b000)
		else $error("interrupt rose without enable");
endmodule

// >>> testbench/host_model.sv
/*
 * Host processor model that reaches the clock through index and data ports.
 * Assumes one-cycle strobes driven 2 ns after the rising clock edge.
 */
module host_model (
	input wire logic ref_clk_i,
	output logic [7:0] io_addr_o,
	output logic io_wr_o,
	output logic io_rd_o,
	output logic [7:0] io_wdata_o,
	input wire logic [7:0] io_rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		io_addr_o = 8'h00;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = 8'h00;
	end
	// Idle write data is inverted so a stale value cannot pass for a fresh one.
	task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
		@(posedge ref_clk_i);
		#2;
		io_addr_o = a;
		io_wdata_o = d;
		io_wr_o = w;
		io_rd_o = r;
		@(posedge ref_clk_i);
		#2;
		io_wr_o = 1'b0;
		io_rd_o = 1'b0;
		io_wdata_o = ~d;
	endtask
	task automatic wr_loc(input logic [6:0] idx, input logic [7:0] d);
		put(rtc_pkg::PORT_INDEX, {1'b0, idx}, 1'b1, 1'b0);
		put(rtc_pkg::PORT_DATA, d, 1'b1, 1'b0);
	endtask
	task automatic rd_loc(input logic [6:0] idx, output logic [7:0] v);
		put(rtc_pkg::PORT_INDEX, {1'b0, idx}, 1'b1, 1'b0);
		put(rtc_pkg::PORT_DATA, 8'h00, 1'b0, 1'b1);
		v = io_rdata_i;
	endtask
	task automatic rd_port(input logic [7:0] a, output logic [7:0] v);
		put(a, 8'h00, 1'b0, 1'b1);
		v = io_rdata_i;
	endtask
endmodule

// >>> testbench/tb.sv
/*
 * Self-checking bench for the indexed clock/calendar.
 * Assumes a shortened timebase: one tick per two clocks, 64 ticks per update.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [6:0] idx; logic [7:0] wr; logic [7:0] exp;} row_s;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, v;
	logic io_wr_i, io_rd_i, irq_o, uip_seen;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	localparam row_s ROWS[16] = '{'{7'h0b, 8'h8a, 8'h8a}, '{7'h0a, 8'ha0, 8'h20},
		'{7'h0d, 8'hff, 8'hbf}, '{7'h0c, 8'hff, 8'h00}, '{7'h00, 8'h59, 8'h59},
		'{7'h02, 8'h59, 8'h59}, '{7'h04, 8'h23, 8'h23}, '{7'h06, 8'h07, 8'h07},
		'{7'h07, 8'h31, 8'h31}, '{7'h08, 8'h12, 8'h12}, '{7'h09, 8'h99, 8'h99},
		'{7'h01, 8'h45, 8'h45}, '{7'h03, 8'h30, 8'h30}, '{7'h05, 8'h12, 8'h12},
		'{7'h0e, 8'h5a, 8'h5a}, '{7'h7f, 8'ha5, 8'ha5}};
	localparam row_s RST_ROWS[6] = '{'{7'h0a, 8'h00, 8'h20}, '{7'h0b, 8'h00, 8'h02},
		'{7'h0d, 8'h00, 8'h80}, '{7'h07, 8'h00, 8'h01}, '{7'h00, 8'h00, 8'h00},
		'{7'h0c, 8'h00, 8'h00}};
	always #20 ref_clk_i = ~ref_clk_i;
	host_model u_host (.ref_clk_i(ref_clk_i), .io_addr_o(io_addr_i), .io_wr_o(io_wr_i),
		.io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i), .io_rdata_i(io_rdata_o));
	rtc_calendar #(.CLK_HZ(32'h0001_0000), .TB_HZ(32'h0000_8000), .PRESC_W(6)) u_dut (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .irq_o(irq_o));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// A lost interrupt must not hang the run, so the wait is bounded.
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 300)
		begin
			@(posedge ref_clk_i);
			n++;
		end
		#2;
	endtask
	// Clears flags, restarts the clock with update interrupts, checks one byte.
	task automatic run_update(input logic [7:0] b, input logic [6:0] ci, input logic [7:0] ce);
		u_host.rd_loc(7'h0c, v);
		u_host.wr_loc(7'h0b, b | 8'h10);
		wait_irq();
		u_host.rd_loc(ci, v);
		chk("updated byte", ce, v);
	endtask
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			stop_test();
		end
	end
	initial
	begin
		repeat (5) @(posedge ref_clk_i);
		#2 rst_n_i = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			u_host.wr_loc(ROWS[i].idx, ROWS[i].wr);
			u_host.rd_loc(ROWS[i].idx, v);
			chk("location", ROWS[i].exp, v);
		end
		$display("test table done");
		repeat (300) @(posedge ref_clk_i);
		u_host.rd_loc(7'h00, v);
		chk("stopped seconds", 8'h59, v);
		u_host.rd_loc(7'h0c, v);
		u_host.wr_loc(7'h0b, 8'h12);
		wait_irq();
		chk("irq", 8'h01, {7'h00, irq_o});
		u_host.rd_loc(7'h0c, v);
		chk("flags", 8'h90, v);
		chk("irq cleared", 8'h00, {7'h00, irq_o});
		u_host.rd_loc(7'h09, v);
		chk("year wrap", 8'h00, v);
		u_host.rd_loc(7'h07, v);
		chk("day wrap", 8'h01, v);
		$display("test update done");
		u_host.wr_loc(7'h0b, 8'h82);
		u_host.wr_loc(7'h01, 8'h05);
		u_host.wr_loc(7'h03, 8'hc0);
		u_host.wr_loc(7'h05, 8'hc0);
		u_host.wr_loc(7'h0d, 8'h01);
		u_host.wr_loc(7'h00, 8'h04);
		u_host.rd_loc(7'h0c, v);
		u_host.wr_loc(7'h0b, 8'h22);
		wait_irq();
		u_host.rd_loc(7'h0c, v);
		chk("alarm flags", 8'hb0, v);
		$display("test alarm done");
		u_host.wr_loc(7'h0b, 8'h80);
		u_host.wr_loc(7'h04, 8'h11);
		u_host.wr_loc(7'h02, 8'h59);
		u_host.wr_loc(7'h00, 8'h59);
		run_update(8'h00, 7'h04, 8'h92);
		u_host.wr_loc(7'h0b, 8'h86);
		u_host.wr_loc(7'h00, 8'h09);
		run_update(8'h06, 7'h00, 8'h0a);
		u_host.wr_loc(7'h0b, 8'h83);
		u_host.wr_loc(7'h06, 8'h01);
		u_host.wr_loc(7'h08, 8'h04);
		u_host.wr_loc(7'h07, 8'h24);
		u_host.wr_loc(7'h04, 8'h01);
		u_host.wr_loc(7'h02, 8'h59);
		u_host.wr_loc(7'h00, 8'h59);
		run_update(8'h03, 7'h04, 8'h03);
		$display("test formats done");
		u_host.wr_loc(7'h0b, 8'h40);
		u_host.wr_loc(7'h0a, 8'h23);
		u_host.rd_loc(7'h0c, v);
		wait_irq();
		u_host.rd_loc(7'h0c, v);
		chk("periodic flags", 8'hc0, v & 8'hc0);
		u_host.wr_loc(7'h0b, 8'h00);
		repeat (20) @(posedge ref_clk_i);
		chk("irq masked", 8'h00, {7'h00, irq_o});
		u_host.rd_loc(7'h0c, v);
		chk("masked flags", 8'h40, v & 8'hc0);
		u_host.rd_port(8'h70, v);
		chk("index port read", 8'h00, v);
		// Polling spans more than one update period, so the busy window must show up.
		uip_seen = 1'b0;
		for (int i = 0; i < 40; i++)
		begin
			u_host.rd_loc(7'h0a, v);
			uip_seen = uip_seen | v[7];
		end
		chk("update busy", 8'h01, {7'h00, uip_seen});
		$display("test periodic done");
		@(posedge ref_clk_i);
		#2 rst_n_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#2 rst_n_i = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			u_host.rd_loc(RST_ROWS[i].idx, v);
			chk("reset value", RST_ROWS[i].exp, v);
		end
		$display("test reset done");
		stop_test();
	end
endmodule
bind rtc_calendar rtc_calendar_asserts u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
	.io_rdata_o(io_rdata_o), .irq_o(irq_o));
